// [bench/ntfc_frame_props.sv]
// Purpose: port-level checks on the target frame control block
// Assumes: bound to ntfc_frame_ctrl, one clock domain
// Notes:   guard bound uses the shortest bit period of all rates
`timescale 1ns/1ps
module ntfc_frame_props
  import ntfc_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Link
  input wire logic        rx_frame_end,
  input wire logic        rx_accept,
  input wire logic        rx_drop,
  input wire logic [15:0] slot_cycles,
  input wire logic        anticoll_start,
  input wire logic        auto_anticollision_cmd,
  input wire logic        tx_start,
  input wire logic        tx_go
);
  localparam int GUARD_MIN = 7 * BIT_CYC_424 - 2;
  logic [15:0] since_rx_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ---
  // Cycles since last frame end, saturating
  // ---
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rx_r <= 16'hFFFF;
    end else if (rx_frame_end) begin
      since_rx_r <= 16'h0000;
    end else if (since_rx_r != 16'hFFFF) begin
      since_rx_r <= since_rx_r + 16'h0001;
    end
  end

  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
  chk_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready too early");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready too early");
  chk_rx_verdict: assert property (rx_accept || rx_drop |->
    $past(rx_frame_end) && !(rx_accept && rx_drop)) else $error("verdict");
  chk_slot_legal: assert property (slot_cycles == SLOT_CYC_212 ||
    slot_cycles == (SLOT_CYC_212 >> 1)) else $error("slot length");
  chk_tx_hold: assert property (tx_start |=> !tx_go)
    else $error("transmit too soon after start");
  chk_tx_guard: assert property (tx_go |-> since_rx_r >= GUARD_MIN)
    else $error("transmit inside guard");
  chk_cmd_start: assert property (anticoll_start |->
    ##[1:2] auto_anticollision_cmd) else $error("command not running");

  cover property (rx_drop);
  cover property (tx_go);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule // ntfc_frame_props

// [bench/ntfc_reader_model.sv]
// Purpose: reader side events for the frame control bench
// Assumes: events are one-cycle pulses on core_clk
// Notes:   frame qualifiers show inverted last value when idle
`timescale 1ns/1ps
module ntfc_reader_model (
  // Clock
  input wire logic  core_clk,
  // Frame events
  output logic       rx_frame_end,
  output logic [8:0] rx_frame_len,
  output logic       rx_crc_ok,
  output logic       rx_is_request,
  output logic [7:0] rx_first_byte,
  // Procedure events
  output logic       select_done,
  output logic       polling_done,
  output logic       rf_reset
);
  initial begin
    {rx_frame_end, rx_frame_len, rx_crc_ok, rx_is_request} = 12'h000;
    rx_first_byte = 8'h00;
    {rf_reset, polling_done, select_done} = 3'h0;
  end

  // Qualifiers only mean something with the end pulse
  task automatic frame(input logic [8:0] l, input logic q,
                       input logic [7:0] b);
    @(posedge core_clk);
    {rx_frame_end, rx_frame_len, rx_crc_ok, rx_is_request} <= {1'b1, l, 2'b11 & {1'b1, q}};
    rx_first_byte <= b;
    @(posedge core_clk);
    {rx_frame_end, rx_frame_len, rx_crc_ok, rx_is_request} <= {1'b0, ~l, 1'b0, ~q};
    rx_first_byte <= ~b;
  endtask

  // 0 select done, 1 polling done, 2 field reset
  task automatic pls(input int k);
    @(posedge core_clk);
    {rf_reset, polling_done, select_done} <= 3'h1 << k;
    @(posedge core_clk);
    {rf_reset, polling_done, select_done} <= 3'h0;
  endtask
endmodule // ntfc_reader_model

// [bench/tb.sv]
// Purpose: self-checking bench for the target frame control block
// Assumes: 100 MHz core clock, AXI4-Lite master tasks
// Notes:   reply timing checked at 424k to keep the run short
`timescale 1ns/1ps
module tb;
  import ntfc_pkg::*;
  logic        core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, card_enter_halt, anticoll_start;
  logic        tx_start, s_axi_awready, s_axi_wready, s_axi_bvalid, tx_go;
  logic        s_axi_arready, s_axi_rvalid, auto_anticollision_cmd;
  logic        rx_accept, rx_drop, active_mode_en, rf_reset, rx_frame_end;
  logic        rx_crc_ok, rx_is_request, select_done, polling_done;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pause_decoder_time_const;
  logic [2:0]  pause_decoder_sensitivity;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  rx_first_byte;
  logic [8:0]  rx_frame_len;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] slot_cycles;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          num_errors, total_checks;

  ntfc_frame_ctrl   DUT (.*);
  ntfc_reader_model rdr (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  // ---
  // Bus master
  // ---
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = 2'h0);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er = 2'h0);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    if (er == 2'h0) chk("rdata", s_axi_rdata, e);
  endtask

  task automatic fr(input logic [8:0] l, input logic [7:0] b,
                    input logic acc, input logic q = 1'b0);
    rdr.frame(l, q, b);
    @(posedge core_clk);
    chk("accept", {rx_accept, rx_drop}, {acc, ~acc});
  endtask

  // ---
  // Scenarios
  // ---
  task automatic s_regs();
    rdc(ADDR_PACKET_LIMITS, {24'h000000, RST_PACKET_LIMITS});
    rdc(ADDR_CARD_MODE, {24'h000000, RST_CARD_MODE});
    wr(ADDR_CARD_MODE, 8'hB9);
    rdc(ADDR_CARD_MODE, 32'h000000B9);
    chk("sens", pause_decoder_sensitivity, 3'h5);
    chk("tau", pause_decoder_time_const, 2'h3);
    wr(12'h004, 8'h5A, 2'h3);
    rdc(12'h004, 32'h0, 2'h3);
    wr(ADDR_CARD_MODE, RST_CARD_MODE);
  endtask

  task automatic s_len();
    wr(ADDR_LINK_CTRL, 8'h01);
    wr(ADDR_PACKET_LIMITS, 8'h02);
    fr(9'h008, 8'h00, 1'b1);
    fr(9'h009, 8'h00, 1'b0);
    wr(ADDR_PACKET_LIMITS, 8'h3F);
    fr(9'h0FC, 8'h00, 1'b1);
    fr(9'h0FD, 8'h00, 1'b0);
    wr(ADDR_PACKET_LIMITS, 8'h00);
    fr(9'h100, 8'h00, 1'b1);
    fr(9'h101, 8'h00, 1'b0);
    wr(ADDR_LINK_CTRL, 8'h00);
    wr(ADDR_PACKET_LIMITS, 8'h01);
    fr(9'h064, 8'h00, 1'b1);
    wr(ADDR_LINK_CTRL, 8'h04);
    fr(9'h064, 8'h00, 1'b0);
    wr(ADDR_PACKET_LIMITS, 8'h00);
  endtask

  task automatic s_slot();
    wr(ADDR_LINK_CTRL, 8'h02);
    repeat (2) @(posedge core_clk);
    chk("slot", slot_cycles, SLOT_CYC_212);
    wr(ADDR_PACKET_LIMITS, 8'h40);
    repeat (2) @(posedge core_clk);
    chk("slot", slot_cycles, SLOT_CYC_212 >> 1);
    wr(ADDR_LINK_CTRL, 8'h01);
    repeat (2) @(posedge core_clk);
    chk("slot", slot_cycles, SLOT_CYC_212);
    wr(ADDR_PACKET_LIMITS, 8'h00);
  endtask

  task automatic s_halt();
    wr(ADDR_LINK_CTRL, 8'h00);
    wr(ADDR_CARD_MODE, 8'h66);
    fr(9'h002, 8'h26, 1'b0, 1'b1);
    fr(9'h002, 8'h52, 1'b1, 1'b1);
    rdr.pls(2);
    rdc(ADDR_CARD_MODE, 32'h00000062);
    fr(9'h002, 8'h26, 1'b1, 1'b1);
    card_enter_halt <= 1'b1;
    @(posedge core_clk);
    card_enter_halt <= 1'b0;
    rdc(ADDR_CARD_MODE, 32'h00000066);
    rdr.pls(2);
  endtask

  task automatic s_chosen();
    wr(ADDR_LINK_CTRL, 8'h09);
    repeat (2) @(posedge core_clk);
    chk("active", active_mode_en, 1'b1);
    wr(ADDR_PACKET_LIMITS, 8'h80);
    repeat (2) @(posedge core_clk);
    chk("active", active_mode_en, 1'b0);
    for (int k = 0; k < 2; k++) begin
      rdr.pls(2);
      anticoll_start <= 1'b1;
      @(posedge core_clk);
      anticoll_start <= 1'b0;
      fr(9'h004, 8'h00, 1'b1);
      chk("cmd", auto_anticollision_cmd, 1'b1);
      rdr.pls(k);
      @(posedge core_clk);
      chk("cmd", auto_anticollision_cmd, 1'b1);
      fr(9'h004, 8'h00, 1'b1);
      repeat (2) @(posedge core_clk);
      chk("cmd", auto_anticollision_cmd, 1'b0);
    end
    wr(ADDR_PACKET_LIMITS, 8'h00);
  endtask

  // Phase trim only shifts the start within one bit period
  task automatic s_reply(input logic [1:0] dx, input int pre);
    int g, n, lo, hi;
    g = (7 + dx) * BIT_CYC_424;
    n = 0;
    wr(ADDR_LINK_CTRL, 8'h32);
    wr(ADDR_CARD_MODE, {6'h18, dx});
    rdr.frame(9'h004, 1'b0, 8'h00);
    repeat (pre) @(posedge core_clk);
    tx_start <= 1'b1;
    @(posedge core_clk);
    tx_start <= 1'b0;
    while (!tx_go) begin
      @(posedge core_clk);
      n++;
    end
    lo = (pre < g) ? g - 2 : pre + 1;
    hi = ((pre < g) ? g : pre) + BIT_CYC_424 + 4;
    n = pre + n + 1;
    chk("reply", n >= lo && n <= hi, 1'b1);
  endtask

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, card_enter_halt} = 3'h0;
    {anticoll_start, tx_start, s_axi_awaddr, s_axi_araddr} = 26'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    s_regs();
    s_len();
    s_slot();
    s_halt();
    s_chosen();
    s_reply(2'h0, 0);
    s_reply(2'h3, 0);
    s_reply(2'h0, 3000);
    end_sim();
  end

  // Run needs about 8k cycles; cut off well past that
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule // tb

bind ntfc_frame_ctrl ntfc_frame_props u_props (.*);

// [verilog/ntfc_frame_ctrl.sv]
// Purpose: target receive framing and reply timing with AXI4-Lite regs
// Assumes: link events are synchronous single-cycle pulses
// Notes:   registers answer one cycle after both channels are taken
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module ntfc_frame_ctrl
  import ntfc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Receive framing
  input  wire logic        rf_reset,
  input  wire logic        rx_frame_end,
  input  wire logic [8:0]  rx_frame_len,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_is_request,
  input  wire logic [7:0]  rx_first_byte,
  input  wire logic        select_done,
  input  wire logic        polling_done,
  input  wire logic        card_enter_halt,
  // Anticollision command
  input  wire logic        anticoll_start,
  output logic             auto_anticollision_cmd,
  // Results
  output logic             rx_accept,
  output logic             rx_drop,
  output logic             active_mode_en,
  output logic [15:0]      slot_cycles,
  output logic [2:0]       pause_decoder_sensitivity,
  output logic [1:0]       pause_decoder_time_const,
  // Transmit
  input  wire logic        tx_start,
  output logic             tx_go
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  target_packet_limits_r;
  logic [7:0]  card_mode_settings_r;
  logic [7:0]  link_ctrl_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        chosen_r;
  logic        wr_fire;
  logic        wr_pl;
  logic        wr_cm;
  logic        wr_lc;

  logic [1:0]  rate;
  logic        sync_detect_enable;
  logic [9:0]  bit_cyc;
  logic [8:0]  max_len;
  logic        len_ok;
  logic        code_ok;
  logic        frame_ok;
  logic        tx_go_int;
  logic        tx_busy_r;
  logic        guard_busy;

  assign rate               = link_ctrl_r[1:0];
  assign sync_detect_enable = link_ctrl_r[SYNC_DET_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_pl   = wr_fire && (awaddr_r == ADDR_PACKET_LIMITS) && wstrb_r[0];
  assign wr_cm   = wr_fire && (awaddr_r == ADDR_CARD_MODE) && wstrb_r[0];
  assign wr_lc   = wr_fire && (awaddr_r == ADDR_LINK_CTRL) && wstrb_r[0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r     <= 1'b1;
        awaddr_r      <= {s_axi_awaddr[11:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status register is read only, unmapped gives DECERR
        if (awaddr_r == ADDR_PACKET_LIMITS || awaddr_r == ADDR_CARD_MODE ||
            awaddr_r == ADDR_LINK_CTRL) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h3;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_packet_limits_r <= RST_PACKET_LIMITS;
      link_ctrl_r            <= RST_LINK_CTRL;
    end else begin
      if (wr_pl) begin
        target_packet_limits_r <= wdata_r[7:0];
      end
      if (wr_lc) begin
        link_ctrl_r <= wdata_r[7:0];
      end
    end
  end

  // Halted flag: hardware set beats host clear, RF reset beats all
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_mode_settings_r <= RST_CARD_MODE;
    end else begin
      if (wr_cm) begin
        card_mode_settings_r <= wdata_r[7:0];
      end
      if (card_enter_halt) begin
        card_mode_settings_r[HALTED_BIT] <= 1'b1;
      end
      if (rf_reset) begin
        card_mode_settings_r[HALTED_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        unique case ({s_axi_araddr[11:2], 2'b00})
          ADDR_PACKET_LIMITS: s_axi_rdata <= {24'h0, target_packet_limits_r};
          ADDR_CARD_MODE:     s_axi_rdata <= {24'h0, card_mode_settings_r};
          ADDR_LINK_CTRL:     s_axi_rdata <= {24'h0, link_ctrl_r};
          ADDR_STATUS:        s_axi_rdata <= {28'h0, tx_busy_r, chosen_r,
                                              auto_anticollision_cmd,
                                              active_mode_en};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet acceptance
  // ----------------------------------------------------------------
  always_comb begin
    if (target_packet_limits_r[MAXLEN_HI:0] == 6'h00) begin
      max_len = MAX_LEN_ZERO;
    end else begin
      max_len = {1'b0, target_packet_limits_r[MAXLEN_HI:0], 2'b00};
    end
  end

  // Limit bypassed at 106k without sync detect
  assign len_ok = (rate == RATE_106 && !sync_detect_enable) ||
                  (rx_frame_len <= max_len);
  assign code_ok = !(card_mode_settings_r[HALTED_BIT] && rate == RATE_106 &&
                     rx_is_request && rx_first_byte != REQ_HALTED_CODE);
  assign frame_ok = rx_crc_ok && len_ok && code_ok;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_accept <= 1'b0;
      rx_drop   <= 1'b0;
    end else begin
      rx_accept <= rx_frame_end && frame_ok;
      rx_drop   <= rx_frame_end && !frame_ok;
    end
  end

  // ----------------------------------------------------------------
  // Anticollision command end
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chosen_r               <= 1'b0;
      auto_anticollision_cmd <= 1'b0;
    end else begin
      if (anticoll_start) begin
        auto_anticollision_cmd <= 1'b1;
        chosen_r               <= 1'b0;
      end else if (auto_anticollision_cmd) begin
        if (select_done || polling_done) begin
          chosen_r <= 1'b1;
        end
        // With chosen-wait clear, selection itself ends the command
        if (target_packet_limits_r[WAIT_CHOSEN_BIT]) begin
          if (chosen_r && rx_frame_end && frame_ok) begin
            auto_anticollision_cmd <= 1'b0;
          end
        end else if (select_done || polling_done) begin
          auto_anticollision_cmd <= 1'b0;
        end
      end
      if (rf_reset) begin
        chosen_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_mode_en            <= 1'b0;
      slot_cycles               <= SLOT_CYC_212;
      pause_decoder_sensitivity <= 3'h0;
      pause_decoder_time_const  <= 2'h0;
    end else begin
      active_mode_en <= link_ctrl_r[ACTIVE_BIT] &&
                        !target_packet_limits_r[WAIT_CHOSEN_BIT];
      if (rate == RATE_424 && target_packet_limits_r[BRIEF_SLOT_BIT]) begin
        slot_cycles <= {1'b0, SLOT_CYC_212[15:1]};
      end else begin
        slot_cycles <= SLOT_CYC_212;
      end
      pause_decoder_sensitivity <=
        card_mode_settings_r[SENS_HI:SENS_LO];
      pause_decoder_time_const <= card_mode_settings_r[TAU_HI:TAU_LO];
    end
  end

  // ----------------------------------------------------------------
  // Reply timing
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rate)
      RATE_212: bit_cyc = BIT_CYC_212;
      RATE_424: bit_cyc = BIT_CYC_424;
      default:  bit_cyc = BIT_CYC_106;
    endcase
  end

  ntfc_reply_timer u_timer (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .bit_cyc             (bit_cyc),
    .reply_delay_extra   (card_mode_settings_r[DELAY_HI:0]),
    .transmit_phase_trim (link_ctrl_r[TRIM_HI:TRIM_LO]),
    .rx_end              (rx_frame_end),
    .tx_start            (tx_start),
    .tx_go               (tx_go_int),
    .guard_busy          (guard_busy)
  );

  // Registered copy keeps tx_go straight from a flip-flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_go     <= 1'b0;
      tx_busy_r <= 1'b0;
    end else begin
      tx_go     <= tx_go_int;
      tx_busy_r <= guard_busy;
    end
  end

endmodule // ntfc_frame_ctrl

// [verilog/ntfc_pkg.sv]
// Purpose: constants for the target frame control block
// Assumes: AXI4-Lite register access, 100 MHz core clock
// Notes:   register indices are printed offsets, byte address = 4 * index
package ntfc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  IDX_PACKET_LIMITS = 8'h1B;
  localparam logic [7:0]  IDX_CARD_MODE     = 8'h1C;
  localparam logic [7:0]  IDX_LINK_CTRL     = 8'h1F;
  localparam logic [7:0]  IDX_STATUS        = 8'h20;
  localparam logic [11:0] ADDR_PACKET_LIMITS = {2'b00, IDX_PACKET_LIMITS, 2'b00};
  localparam logic [11:0] ADDR_CARD_MODE     = {2'b00, IDX_CARD_MODE, 2'b00};
  localparam logic [11:0] ADDR_LINK_CTRL     = {2'b00, IDX_LINK_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STATUS        = {2'b00, IDX_STATUS, 2'b00};

  localparam logic [7:0] RST_PACKET_LIMITS = 8'h00;
  localparam logic [7:0] RST_CARD_MODE     = 8'h62;
  localparam logic [7:0] RST_LINK_CTRL     = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int WAIT_CHOSEN_BIT = 7;
  localparam int BRIEF_SLOT_BIT  = 6;
  localparam int MAXLEN_HI       = 5;
  localparam int SENS_HI         = 7;
  localparam int SENS_LO         = 5;
  localparam int TAU_HI          = 4;
  localparam int TAU_LO          = 3;
  localparam int HALTED_BIT      = 2;
  localparam int DELAY_HI        = 1;
  // Link control: [1:0] rate, [2] sync detect, [3] active, [6:4] phase trim
  localparam int SYNC_DET_BIT    = 2;
  localparam int ACTIVE_BIT      = 3;
  localparam int TRIM_LO         = 4;
  localparam int TRIM_HI         = 6;

  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] RATE_424 = 2'h2;

  // ------------------------------------------------------------------
  // Timing and framing
  // ------------------------------------------------------------------
  localparam logic [7:0]  REQ_HALTED_CODE = 8'h52;
  localparam logic [8:0]  MAX_LEN_ZERO    = 9'h100;
  localparam logic [3:0]  BASE_REPLY_BITS = 4'h7;
  // Bit period in core cycles (about 9.44 us / 10 ns at 106k)
  localparam logic [9:0]  BIT_CYC_106     = 10'h3B0;
  localparam logic [9:0]  BIT_CYC_212     = 10'h1D8;
  localparam logic [9:0]  BIT_CYC_424     = 10'h0EC;
  localparam logic [15:0] SLOT_CYC_212    = 16'h1DC4;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_WAIT  = 2'b01,
    TX_ALIGN = 2'b10,
    TX_SEND  = 2'b11
  } ntfc_tx_t;

endpackage

// [verilog/ntfc_reply_timer.sv]
// Purpose: receive-to-transmit guard and bit alignment
// Assumes: rx_end pulse at end of each received frame
// Notes:   counts bits from receive end, then waits for phase edge
`timescale 1ns/1ps
module ntfc_reply_timer
  import ntfc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic [9:0] bit_cyc,
  input  wire logic [1:0] reply_delay_extra,
  input  wire logic [2:0] transmit_phase_trim,
  // Events
  input  wire logic       rx_end,
  input  wire logic       tx_start,
  // Result
  output logic            tx_go,
  output logic            guard_busy
);

  logic [9:0] cyc_r;
  logic [3:0] bits_r;
  logic       armed_r;
  logic       pend_r;
  logic [3:0] need;
  logic       elapsed;
  logic       at_phase;

  assign need     = BASE_REPLY_BITS + {2'b00, reply_delay_extra};
  assign elapsed  = !armed_r || (bits_r >= need);
  assign at_phase = (cyc_r == {7'h00, transmit_phase_trim});
  assign guard_busy = !elapsed;

  // ----------------------------------------------------------------
  // Bit clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 10'h000;
    end else if (rx_end || cyc_r >= bit_cyc - 10'h001) begin
      cyc_r <= 10'h000;
    end else begin
      cyc_r <= cyc_r + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_r  <= 4'h0;
      armed_r <= 1'b0;
    end else if (rx_end) begin
      bits_r  <= 4'h0;
      armed_r <= 1'b1;
    end else if (cyc_r >= bit_cyc - 10'h001 && bits_r != 4'hF) begin
      bits_r <= bits_r + 4'h1;
    end
  end

  // Start held until guard over and bit phase matches
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      tx_go  <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      if ((pend_r || tx_start) && elapsed && at_phase) begin
        pend_r <= 1'b0;
        tx_go  <= 1'b1;
      end else if (tx_start) begin
        pend_r <= 1'b1;
      end
    end
  end

endmodule // ntfc_reply_timer
